// *** rail_sequence_reset_ctrl.sv ***
// Rail sequencer, reset output and power-cycle controller.
// Assumes synchronous inputs; rst_i is the lockout (power-on) reset.
`timescale 1ns/1ps
`include "rsrc_cfg.svh"
module rail_sequence_reset_ctrl #(
    parameter int STEP_CYC = `RSRC_STEP_CYC,
    parameter int RST_CYC = `RSRC_RST_CYC,
    parameter int REQ_CYC = `RSRC_REQ_CYC,
    parameter longint TPC_CYC = `RSRC_TPC_CYC,
    parameter int OFF_CYC = `RSRC_OFF_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Rail status, index 0 is rail 1
    input wire logic [12:0] rail_good_i,
    // Unused pins of this option
    input wire logic pushbutton_in_n_i,
    input wire logic voltage_select_in_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Rail enables and reset
    output logic [12:0] rail_en_o,
    output logic [12:0] rail_vsel_o,
    output logic reset_out_n_o
);
    rsrc_pkg::rsrc_state_t state;
    rsrc_pkg::rsrc_state_t next_state;

    logic timed_power_cycle_enable;
    logic software_power_cycle;
    logic manual_reset_request;
    logic [1:0] host_rail_en; // bit0 rail 5, bit1 rail 13
    logic watchdog_en;
    logic [31:0] off_cnt;
    logic [31:0] mr_cnt;
    logic [31:0] spc_cnt;
    logic [63:0] tpc_cnt;
    logic mr_fired;
    logic spc_fired;
    logic tpc_fired;
    logic cycle_pend;
    logic manual_reset_request_fired_hold;

    // Write decode
    wire wr_tpc = reg_wr_i && (reg_addr_i == `RSRC_ADDR_TPC);
    wire wr_spc = reg_wr_i && (reg_addr_i == `RSRC_ADDR_SPC);
    wire wr_mr = reg_wr_i && (reg_addr_i == `RSRC_ADDR_MR);
    wire wr_railen = reg_wr_i && (reg_addr_i == `RSRC_ADDR_RAILEN);
    wire wr_shut = reg_wr_i && (reg_addr_i == `RSRC_ADDR_SHUT);
    wire wr_wdg = reg_wr_i && (reg_addr_i == `RSRC_ADDR_WDG);
    wire wbit = reg_wdata_i[`RSRC_BIT0];
    wire shutdown_cmd = wr_shut && wbit;
    wire cycle_req = spc_fired || tpc_fired;
    wire running = (state == rsrc_pkg::RSRC_SEQ) ||
        (state == rsrc_pkg::RSRC_RUN);
    wire [12:0] g = rail_good_i;

    // Trigger chain, each stage gated by the trigger rail's power good
    logic d_r6;
    logic d_r4;
    logic d_r3;
    logic d_r1;
    logic d_rst;
    rsrc_delay #(.CYCLES(STEP_CYC)) u_d_r6 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .trig_i(running && g[1]),
        .done_o(d_r6)
    );
    rsrc_delay #(.CYCLES(STEP_CYC)) u_d_r4 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .trig_i(running && g[9]),
        .done_o(d_r4)
    );
    rsrc_delay #(.CYCLES(STEP_CYC)) u_d_r3 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .trig_i(running && g[3]),
        .done_o(d_r3)
    );
    rsrc_delay #(.CYCLES(STEP_CYC)) u_d_r1 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .trig_i(running && g[11]),
        .done_o(d_r1)
    );
    rsrc_delay #(.CYCLES(RST_CYC)) u_d_rst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .trig_i(running && g[3]),
        .done_o(d_rst)
    );

    // Next enables; index n-1 is rail n
    logic [12:0] next_en;
    always_comb begin
        next_en = '0;
        if (running) begin
            next_en[1] = 1'b1;
            next_en[10] = 1'b1;
            next_en[9:5] = {5{d_r6}};
            next_en[3] = d_r4;
            next_en[2] = d_r3;
            next_en[11] = d_r3;
            next_en[0] = d_r1;
            next_en[4] = host_rail_en[0];
            next_en[12] = host_rail_en[1];
        end
    end

    // Sequencer; off time gives rails a chance to discharge
    always_comb begin
        next_state = state;
        case (state)
            rsrc_pkg::RSRC_OFF: begin
                next_state = rsrc_pkg::RSRC_SEQ;
            end
            rsrc_pkg::RSRC_SEQ: begin
                if (shutdown_cmd || cycle_req) begin
                    next_state = rsrc_pkg::RSRC_DOWN;
                end else if (d_r1) begin
                    next_state = rsrc_pkg::RSRC_RUN;
                end
            end
            rsrc_pkg::RSRC_RUN: begin
                if (shutdown_cmd || cycle_req) begin
                    next_state = rsrc_pkg::RSRC_DOWN;
                end
            end
            rsrc_pkg::RSRC_DOWN: begin
                // Shutdown stays down until the next lockout reset
                if (off_cnt == 32'(OFF_CYC - 1) && cycle_pend) begin
                    next_state = rsrc_pkg::RSRC_SEQ;
                end
            end
            default: next_state = rsrc_pkg::RSRC_OFF;
        endcase
    end

    wire off_at = (off_cnt == 32'(OFF_CYC - 1));
    wire [31:0] next_off_cnt = (state != rsrc_pkg::RSRC_DOWN) ? '0
        : (off_at ? off_cnt : off_cnt + 32'd1);
    // Pending cycle latched on entry to the down state, held while there
    wire next_cycle_pend = (state == rsrc_pkg::RSRC_DOWN) ? cycle_pend
        : (cycle_req && !shutdown_cmd);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= rsrc_pkg::RSRC_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            off_cnt <= '0;
            cycle_pend <= 1'b0;
        end else begin
            off_cnt <= next_off_cnt;
            cycle_pend <= next_cycle_pend;
        end
    end

    // Registers written by the host
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            timed_power_cycle_enable <= 1'b0;
            software_power_cycle <= 1'b0;
            manual_reset_request <= 1'b0;
            host_rail_en <= 2'b00;
            watchdog_en <= 1'b0;
        end else begin
            if (wr_tpc) timed_power_cycle_enable <= wbit;
            if (wr_spc) software_power_cycle <= wbit;
            else if (spc_fired) software_power_cycle <= 1'b0;
            if (wr_mr) manual_reset_request <= wbit;
            else if (spc_fired) manual_reset_request <= 1'b0;
            if (wr_railen) host_rail_en <= reg_wdata_i[1:0];
            if (wr_wdg) watchdog_en <= wbit;
            if (state == rsrc_pkg::RSRC_DOWN) host_rail_en <= 2'b00;
        end
    end

    // Timers from request bit set to action
    wire mr_at = (mr_cnt == 32'(REQ_CYC - 1));
    wire spc_at = (spc_cnt == 32'(REQ_CYC - 1));
    wire tpc_at = (tpc_cnt == 64'(TPC_CYC - 1));
    // Counters stop at the end: spc and tpc fire once per set, mr_fired stays high while the bit stays set
    wire [31:0] next_mr_cnt = !manual_reset_request ? '0
        : (mr_at ? mr_cnt : mr_cnt + 32'd1);
    wire [31:0] next_spc_cnt = !software_power_cycle ? '0
        : (spc_at ? spc_cnt : spc_cnt + 32'd1);
    wire [63:0] next_tpc_cnt = !timed_power_cycle_enable ? '0
        : (tpc_at ? tpc_cnt : tpc_cnt + 64'd1);
    wire next_mr_fired = manual_reset_request && mr_at;
    wire next_spc_fired = software_power_cycle && spc_at && !spc_fired;
    wire next_tpc_fired = timed_power_cycle_enable && !tpc_at
        && (tpc_cnt == 64'(TPC_CYC - 2));

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            mr_cnt <= '0;
            mr_fired <= 1'b0;
        end else begin
            mr_cnt <= next_mr_cnt;
            mr_fired <= next_mr_fired;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            spc_cnt <= '0;
            spc_fired <= 1'b0;
        end else begin
            spc_cnt <= next_spc_cnt;
            spc_fired <= next_spc_fired;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tpc_cnt <= '0;
            tpc_fired <= 1'b0;
        end else begin
            tpc_cnt <= next_tpc_cnt;
            tpc_fired <= next_tpc_fired;
        end
    end

    // Outputs
    wire [7:0] stat = {2'b00, watchdog_en, mr_fired, d_rst,
        state == rsrc_pkg::RSRC_RUN, state == rsrc_pkg::RSRC_DOWN,
        running};
    wire [7:0] rd_mux =
        (reg_addr_i == `RSRC_ADDR_TPC) ? {7'h00, timed_power_cycle_enable}
        : (reg_addr_i == `RSRC_ADDR_SPC) ? {7'h00, software_power_cycle}
        : (reg_addr_i == `RSRC_ADDR_MR) ? {7'h00, manual_reset_request}
        : (reg_addr_i == `RSRC_ADDR_RAILEN) ? {6'h00, host_rail_en}
        : (reg_addr_i == `RSRC_ADDR_STAT) ? stat
        : (reg_addr_i == `RSRC_ADDR_WDG) ? {7'h00, watchdog_en}
        : 8'h00;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
            rail_en_o <= '0;
            rail_vsel_o <= '0;
            reset_out_n_o <= 1'b0;
        end else begin
            if (reg_rd_i) reg_rdata_o <= rd_mux;
            rail_en_o <= next_en;
            rail_vsel_o <= '0;
            reset_out_n_o <= d_rst && g[3] && !mr_fired
                && !manual_reset_request_fired_hold;
        end
    end

    // Reset stays asserted once the manual request matured, until the request bit clears or the sequence restarts
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            manual_reset_request_fired_hold <= 1'b0;
        end else if (state == rsrc_pkg::RSRC_SEQ) begin
            manual_reset_request_fired_hold <= 1'b0;
        end else if (mr_fired) begin
            manual_reset_request_fired_hold <= 1'b1;
        end else if (!manual_reset_request) begin
            manual_reset_request_fired_hold <= 1'b0;
        end
    end
endmodule : rail_sequence_reset_ctrl

// *** rsrc_cfg.svh ***
// Constants and timing for the rail sequencing and reset controller.
// Assumes a 250 MHz system clock; included by the controller and the delay timer.
//
// Contract
// - Power-up sequence starts by itself once input power is applied.
// - Rails 2 and 11 enable at lockout release with no delay.
// - Rails 6 to 10 enable 2000 us after rail 2 is good.
// - Rail 4 after 10, rails 3 and 12 after 4, rail 1 after 12.
// - Rails 5 and 13 stay off until the host enables them.
// - Reset output releases 40 ms after rail 4 good, held while not good.
// - Host shutdown command turns every output off; pushbutton unused.
// - No voltage scaling: each rail keeps one voltage setting.
// - Watchdog functions start disabled and trigger nothing until enabled.
// - Reset output asserts 8 ms after manual reset request is set.
// - Full power cycle starts 8 ms after software power-cycle bit set.
// - Timed power-cycle enable set causes a power cycle 4 s later.
`ifndef RSRC_CFG_SVH
`define RSRC_CFG_SVH

`define RSRC_CLK_MHZ 250
`define RSRC_STEP_US 2000
`define RSRC_RST_MS 40
`define RSRC_REQ_MS 8
`define RSRC_TPC_S 4
`define RSRC_STEP_CYC (`RSRC_STEP_US * `RSRC_CLK_MHZ)
`define RSRC_RST_CYC (`RSRC_RST_MS * 1000 * `RSRC_CLK_MHZ)
`define RSRC_REQ_CYC (`RSRC_REQ_MS * 1000 * `RSRC_CLK_MHZ)
`define RSRC_TPC_CYC (64'd`RSRC_TPC_S * 64'd1000000 * 64'd`RSRC_CLK_MHZ)
`define RSRC_OFF_CYC 32'd1000

`define RSRC_ADDR_TPC 8'hc0
`define RSRC_ADDR_SPC 8'hc3
`define RSRC_ADDR_MR 8'hd3
`define RSRC_ADDR_RAILEN 8'h10
`define RSRC_ADDR_SHUT 8'h11
`define RSRC_ADDR_STAT 8'h12
`define RSRC_ADDR_WDG 8'h13
`define RSRC_BIT0 0
`define RSRC_NRAIL 13

`endif

// *** rsrc_ctrl_asserts.sv ***
// Checker for the rail sequencer outputs against rail status.
// Sees only the controller ports; bound to it below.
`timescale 1ns/1ps
module rsrc_ctrl_asserts #(
    parameter int RST_CYC = 50
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Watched signals
    input wire logic [12:0] rail_good_i,
    input wire logic [12:0] rail_en_o,
    input wire logic [12:0] rail_vsel_o,
    input wire logic reset_out_n_o
);
    int good4_cnt;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            good4_cnt <= 0;
        end else if (!rail_good_i[3]) begin
            good4_cnt <= 0;
        end else if (good4_cnt < RST_CYC + 8) begin
            good4_cnt <= good4_cnt + 1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_r2_lost;
        !rail_good_i[1] [*4];
    endsequence
    chk_vsel_fixed: assert property (rail_vsel_o == 13'h0000)
        else $error("rail_vsel_o not zero");
    chk_root_pair: assert property (
        $rose(rail_en_o[1]) |-> rail_en_o[10])
        else $error("rails 2 and 11 not together");
    chk_mid_trigger: assert property (
        $rose(rail_en_o[5]) |-> rail_good_i[1])
        else $error("rail 6 on without rail 2 good");
    chk_rail4_trigger: assert property (
        $rose(rail_en_o[3]) |-> rail_good_i[9])
        else $error("rail 4 on without rail 10 good");
    chk_rail3_trigger: assert property (
        $rose(rail_en_o[2]) |-> rail_good_i[3])
        else $error("rail 3 on without rail 4 good");
    chk_rail1_trigger: assert property (
        $rose(rail_en_o[0]) |-> rail_good_i[11])
        else $error("rail 1 on without rail 12 good");
    chk_reset_gate: assert property (
        !rail_good_i[3] |=> !reset_out_n_o)
        else $error("reset released while rail 4 bad");
    chk_release_wait: assert property (
        $rose(reset_out_n_o) |-> good4_cnt >= RST_CYC)
        else $error("reset released too early");
    chk_drop_clears: assert property (s_r2_lost |-> !rail_en_o[5])
        else $error("rail 6 on after rail 2 lost");
endmodule : rsrc_ctrl_asserts

bind rail_sequence_reset_ctrl rsrc_ctrl_asserts #(.RST_CYC(RST_CYC)) u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .rail_good_i(rail_good_i),
    .rail_en_o(rail_en_o),
    .rail_vsel_o(rail_vsel_o),
    .reset_out_n_o(reset_out_n_o)
);

// *** rsrc_delay.sv ***
// Trigger-to-done delay timer for one sequencing step or the reset release.
// Assumes a synchronous trigger; the count restarts whenever it drops.
`timescale 1ns/1ps
`include "rsrc_cfg.svh"
module rsrc_delay #(
    parameter int CYCLES = `RSRC_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Trigger and result
    input wire logic trig_i,
    output logic done_o
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    logic [W-1:0] count;
    wire at_end = (count == LAST);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
            done_o <= 1'b0;
        end else if (!trig_i) begin
            count <= '0;
            done_o <= 1'b0;
        end else if (!done_o) begin
            count <= count + W'(1);
            done_o <= at_end;
        end
    end
endmodule : rsrc_delay

// *** rsrc_pkg.sv ***
// Types for the rail sequencing and reset controller.
// Assumes nothing beyond a SystemVerilog compiler.
package rsrc_pkg;
    typedef enum logic [1:0] {
        RSRC_OFF = 2'b00,
        RSRC_SEQ = 2'b01,
        RSRC_RUN = 2'b11,
        RSRC_DOWN = 2'b10
    } rsrc_state_t;
endpackage : rsrc_pkg

// *** rsrc_rail_model.sv ***
// Rail model: each rail reports good a few cycles after its enable.
// Assumes the controller clock; kill_i cuts a rail at once.
`timescale 1ns/1ps
module rsrc_rail_model #(
    parameter int RISE_CYC = 3
) (
    // Clock
    input wire logic clk_sys_i,
    // Enables and faults
    input wire logic [12:0] rail_en_i,
    input wire logic [12:0] kill_i,
    // Power good
    output logic [12:0] rail_good_o
);
    logic [12:0] dly_q [RISE_CYC];
    always_ff @(posedge clk_sys_i) begin
        dly_q[0] <= rail_en_i & ~kill_i;
        for (int i = 1; i < RISE_CYC; i++) begin
            dly_q[i] <= dly_q[i-1] & rail_en_i & ~kill_i;
        end
    end
    // Good drops with no lag, as a real rail would
    assign rail_good_o = dly_q[RISE_CYC-1] & rail_en_i & ~kill_i;
endmodule : rsrc_rail_model

// *** tb.sv ***
// Testbench for the rail sequencer with a rail model on its outputs.
// Assumes shortened counts; all waits are bounded.
`timescale 1ns/1ps
module tb;
    localparam int STEP = 20;
    localparam int RSTC = 50;
    localparam int REQ = 30;
    localparam int TPC = 100;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic pb_n = 1'b1;
    logic vsel = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic [12:0] kill = 13'h0000;
    logic [12:0] good;
    logic [12:0] en;
    logic [12:0] vsel_o;
    logic rst_n;
    wire [26:0] obs = {rst_n, good, en};
    int bad_count = 0;
    int checked = 0;
    int n;
    always #2 clk_sys_i = ~clk_sys_i;
    rail_sequence_reset_ctrl #(.STEP_CYC(STEP), .RST_CYC(RSTC),
        .REQ_CYC(REQ), .TPC_CYC(64'(TPC)), .OFF_CYC(10)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rail_good_i(good),
        .pushbutton_in_n_i(pb_n), .voltage_select_in_i(vsel),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .rail_en_o(en),
        .rail_vsel_o(vsel_o), .reset_out_n_o(rst_n));
    rsrc_rail_model u_rails (.clk_sys_i(clk_sys_i), .rail_en_i(en),
        .kill_i(kill), .rail_good_o(good));
    task automatic report_and_stop();
        $display("Checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp(input string what, input logic [12:0] e,
                       input logic [12:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic cmp_n(input string what, input int lo, input int hi,
                         input int g);
        checked++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("Error %s expected %0d..%0d seen %0d",
                what, lo, hi, g);
        end
    endtask : cmp_n
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        rd = 1'b1;
        addr = a;
        tick(1);
        rd = 1'b0;
        d = rdata;
        tick(1);
    endtask : rd_reg
    task automatic wait_on(input logic [26:0] m, input logic [26:0] v,
                           output int k);
        k = 0;
        while ((obs & m) !== v && k < 2000) begin
            tick(1);
            k++;
        end
        if ((obs & m) !== v) begin
            bad_count++;
            $display("Error wait expected %h seen %h", v, obs & m);
        end
    endtask : wait_on
    initial begin
        #20000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        tick(5);
        rst_i = 1'b0;
        pb_n = 1'b0;
        vsel = 1'b1;
        tick(3);
        cmp("root rails", 13'h0402, en);
        wait_on(27'h10000, 27'h10000, n);
        cmp_n("rail 4 time", 2*STEP, 2*STEP+20, n);
        wait_on(27'h4000000, 27'h4000000, n);
        cmp_n("reset release", RSTC-2, RSTC+3, n);
        wait_on(27'h1, 27'h1, n);
        cmp("chain", 13'h0fef, en);
        rd_reg(8'h13, rv);
        cmp("watchdog", 13'h0, {5'h0, rv});
        wr_reg(8'h55, 8'hff);
        rd_reg(8'h55, rv);
        cmp("unmapped", 13'h0, {5'h0, rv});
        wr_reg(8'h10, 8'h03);
        tick(2);
        cmp("host rails", 13'h1fff, en);
        cmp("single setting", 13'h0, vsel_o);
        kill = 13'h0008;
        tick(3);
        cmp("reset on loss", 13'h0, {12'h0, rst_n});
        tick(4);
        cmp("dependents off", 13'h0, en & 13'h0805);
        kill = 13'h0000;
        wait_on(27'h4000000, 27'h4000000, n);
        cmp_n("release again", RSTC+1, RSTC+6, n);
        wait_on(27'h1, 27'h1, n);
        wr_reg(8'hd3, 8'h01);
        wr_reg(8'hc3, 8'h01);
        wait_on(27'h4000000, 27'h0, n);
        cmp_n("manual reset", REQ-5, REQ+1, n);
        wait_on(27'h1fff, 27'h0, n);
        cmp_n("power cycle", 0, 6, n);
        wait_on(27'h1, 27'h1, n);
        cmp("restart", 13'h0fef, en);
        wr_reg(8'hc0, 8'h01);
        wait_on(27'h1fff, 27'h0, n);
        cmp_n("timed cycle", TPC-4, TPC+3, n);
        wait_on(27'h1, 27'h1, n);
        wr_reg(8'hc0, 8'h00);
        rd_reg(8'hc0, rv);
        cmp("timed enable", 13'h0, {5'h0, rv});
        tick(TPC+20);
        cmp("no repeat", 13'h0fef, en);
        kill = 13'h0002;
        tick(8);
        cmp("mid rails drop", 13'h0, en & 13'h03e0);
        wr_reg(8'h11, 8'h01);
        tick(4*STEP);
        cmp("shutdown", 13'h0, en);
        cmp("shutdown reset", 13'h0, {12'h0, rst_n});
        rd_reg(8'h12, rv);
        cmp("status", 13'h0002, {5'h0, rv});
        report_and_stop();
    end
endmodule : tb
